// ===== rtl/sea_pkg.sv
// constants, types and step decoding for the serial eeprom access port
// assumes one 125 MHz clock and a synchronous active-low reset
package sea_pkg;

  // configuration word and its fields
  localparam logic [11:0] CFG_EEPROM_OFS = 12'h0BC;
  localparam int          START_BIT      = 0;
  localparam int          CMD_BIT        = 1;
  localparam int          ERR_BIT        = 2;
  localparam int          AL_OK_BIT      = 3;
  localparam int          AL_FUND_BIT    = 4;
  localparam int          AL_DIS_BIT     = 5;
  localparam int          RATE_LSB       = 6;
  localparam int          RSVD_BIT       = 8;
  localparam int          ADDR_LSB       = 9;
  localparam int          DATA_LSB       = 16;

  // reset values
  localparam logic        RST_AL_DIS = 1'b1;
  localparam logic [1:0]  RST_RATE   = 2'h1;

  // clock rate codes; 00 and 10 are reserved and run as the standard rate
  localparam logic [1:0]  RATE_STD  = 2'h1;
  localparam logic [1:0]  RATE_TEST = 2'h3;

  // serial clock: primary clock (125 MHz) divided by 1024, in quarter periods
  localparam int          PRIMARY_CLK_MHZ = 125;
  localparam int          SCL_DIV_STD     = 1024;
  localparam int          SCL_DIV_TEST    = 16;
  localparam logic [7:0]  QTR_STD_M1      = 8'(SCL_DIV_STD / 4 - 1);
  localparam logic [7:0]  QTR_TEST_M1     = 8'(SCL_DIV_TEST / 4 - 1);

  // eeprom addressing and autoload image
  localparam logic [6:0]  DEV_ADDR     = 7'h50;
  localparam logic [15:0] AL_SIG       = 16'h5A5A; // arbitrary value
  localparam logic [6:0]  AL_LAST_WORD = 7'h7F;

  // transaction step list
  localparam logic [3:0]  WR_STOP_STEP    = 4'h5;
  localparam logic [3:0]  RD_RESTART_STEP = 4'h3;
  localparam logic [3:0]  RD_HI_STEP      = 4'h5;
  localparam logic [3:0]  RD_STOP_STEP    = 4'h7;

  typedef enum logic [2:0] {OP_START, OP_SEND, OP_RECV, OP_STOP, OP_END} sea_op_t;
  typedef enum logic {S_IDLE, S_RUN} sea_seq_t;

  function automatic logic [3:0] stop_step(input logic wr);
    return wr ? WR_STOP_STEP : RD_STOP_STEP;
  endfunction

  function automatic sea_op_t step_op(input logic [3:0] step, input logic wr);
    sea_op_t op;
    op = OP_END;
    if (step == 4'h0 || (!wr && step == RD_RESTART_STEP)) begin
      op = OP_START;
    end else if (step == stop_step(wr)) begin
      op = OP_STOP;
    end else if (step < stop_step(wr)) begin
      op = (!wr && step >= RD_HI_STEP) ? OP_RECV : OP_SEND;
    end
    return op;
  endfunction

endpackage

// ===== rtl/sea_ctl_if.sv
// signals between the access port core, its rate divider and its pin synchroniser
// assumes all three sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface sea_ctl_if;
  logic [1:0] rate;
  logic       tick;
  logic       sda_pin;
  logic       sda_seen;
  modport div  (input rate, output tick);
  modport sync (input sda_pin, output sda_seen);
  modport core (output rate, output sda_pin, input tick, input sda_seen);
endinterface
`default_nettype wire

// ===== rtl/sea_tick_gen.sv
// quarter-period tick for the serial clock, chosen by the rate field
// assumes the rate may change at any time; a change to the test rate then wraps the count early
`timescale 1ns/1ps
`default_nettype none
module sea_tick_gen (
  input  wire logic clk,
  input  wire logic nrst,
  sea_ctl_if.div    ctl
);
  import sea_pkg::*;

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       tick_q;
  logic       next_tick;
  logic [7:0] limit;

  always_comb begin
    limit     = (ctl.rate == RATE_TEST) ? QTR_TEST_M1 : QTR_STD_M1;
    next_tick = (cnt >= limit);
    next_cnt  = next_tick ? 8'h00 : cnt + 8'h01;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt    <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      tick_q <= next_tick;
    end
  end

  assign ctl.tick = tick_q;

  // helper: cycles since the last tick, and whether the rate stayed standard
  logic [8:0] gap;
  logic       std_run;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gap     <= 9'h000;
      std_run <= 1'b0;
    end else begin
      gap     <= tick_q ? 9'h001 : gap + 9'h001;
      std_run <= tick_q ? (ctl.rate == RATE_STD) : (std_run && ctl.rate == RATE_STD);
    end
  end

  property p_tick_gap;
    @(posedge clk) disable iff (!nrst)
      (tick_q && std_run && ctl.rate == RATE_STD) |-> (gap == 9'(SCL_DIV_STD / 4));
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("serial clock quarter not 256 cycles");

endmodule
`default_nettype wire

// ===== rtl/sea_pin_sync.sv
// three-stage synchroniser for the data pin coming back from the eeprom
// assumes the pin is asynchronous; a change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sea_pin_sync (
  input  wire logic clk,
  input  wire logic nrst,
  sea_ctl_if.sync   ctl
);
  import sea_pkg::*;

  logic [2:0] stage;
  logic       seen;
  logic       next_seen;

  always_comb begin
    next_seen = (stage[1] == stage[2]) ? stage[2] : seen;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stage <= 3'h7;
      seen  <= 1'b1;
    end else begin
      stage <= {stage[1:0], ctl.sda_pin};
      seen  <= next_seen;
    end
  end

  assign ctl.sda_seen = seen;

endmodule
`default_nettype wire

// ===== rtl/sea_access_port.sv
// eeprom access port: configuration word, two-wire cycle engine, autoload
// assumes config reads/writes are one-cycle strobes on clk and the pins are open drain
`timescale 1ns/1ps
`default_nettype none

module sea_access_port (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        hot_reset,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rd_valid,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             al_valid,
  output logic      [6:0]  al_addr,
  output logic      [15:0] al_data,
  output logic             al_busy
);
  import sea_pkg::*;

  sea_ctl_if ctl ();

  sea_tick_gen u_tick (
    .clk  (clk),
    .nrst (nrst),
    .ctl  (ctl)
  );

  sea_pin_sync u_sync (
    .clk  (clk),
    .nrst (nrst),
    .ctl  (ctl)
  );

  function automatic logic cfg_hit(input logic [11:0] addr);
    return addr == CFG_EEPROM_OFS;
  endfunction

  // register file
  logic        start,   next_start;
  logic        cmd,     next_cmd;
  logic        err,     next_err;
  logic        al_ok,   next_al_ok;
  logic        al_fund, next_al_fund;
  logic        al_dis,  next_al_dis;
  logic        al_first, next_al_first;
  logic [1:0]  rate,    next_rate;
  logic [6:0]  waddr,   next_waddr;
  logic [15:0] wdata,   next_wdata;
  logic [31:0] next_cfg_rdata;
  logic [31:0] word;

  // sequencer and bit engine
  sea_seq_t    seq_st,  next_seq_st;
  sea_op_t     op;
  logic        job_al,  next_job_al;
  logic        job_wr,  next_job_wr;
  logic [3:0]  step,    next_step;
  logic [1:0]  q,       next_q;
  logic [3:0]  bitn,    next_bitn;
  logic [7:0]  shreg,   next_shreg;
  logic [15:0] rx_word, next_rx_word;
  logic        nacked,  next_nacked;
  logic        next_scl_oe, next_sda_oe;
  logic        al_req,  next_al_req;
  logic [6:0]  al_idx,  next_al_idx;
  logic        next_al_valid, next_al_busy;
  logic [6:0]  next_al_addr;
  logic [15:0] next_al_data;
  logic        ev_sw_done, ev_al_end, ev_al_pass, ok_word;
  logic        pin_low;

  assign ctl.rate    = rate;
  assign ctl.sda_pin = sda_i;
  assign op          = step_op(step, job_wr);

  function automatic logic [7:0] byte_for(input logic [3:0] s, input logic wr,
                                          input logic [6:0] a, input logic [15:0] d);
    logic [7:0] b;
    b = 8'h00;
    if (s == 4'h1) begin
      b = {DEV_ADDR, 1'b0};
    end else if (s == 4'h2) begin
      b = {a, 1'b0};
    end else if (wr && s == 4'h3) begin
      b = d[15:8];
    end else if (wr && s == 4'h4) begin
      b = d[7:0];
    end else if (!wr && s == 4'h4) begin
      b = {DEV_ADDR, 1'b1};
    end
    return b;
  endfunction

  assign word = {wdata, waddr, 1'b0, rate, al_dis, al_fund, al_ok, err, cmd, start};

  always_comb begin
    next_start     = start;
    next_cmd       = cmd;
    next_err       = err;
    next_al_ok     = al_ok;
    next_al_fund   = al_fund;
    next_al_dis    = al_dis;
    next_al_first  = al_first;
    next_rate      = rate;
    next_waddr     = waddr;
    next_wdata     = wdata;
    next_cfg_rdata = (cfg_rd && cfg_hit(cfg_addr)) ? word : 32'h0000_0000;
    // a busy cycle owns the word, so writes during it are dropped
    if (cfg_wr && cfg_hit(cfg_addr) && !start) begin
      if (cfg_be[0]) begin
        next_start  = cfg_wdata[START_BIT];
        next_cmd    = cfg_wdata[CMD_BIT];
        next_al_dis = cfg_wdata[AL_DIS_BIT];
        next_rate   = cfg_wdata[RATE_LSB +: 2];
        if (cfg_wdata[START_BIT]) begin
          next_err = 1'b0;
        end
      end
      if (cfg_be[1]) begin
        next_waddr = cfg_wdata[ADDR_LSB +: 7];
      end
      if (cfg_be[2]) begin
        next_wdata[7:0] = cfg_wdata[DATA_LSB +: 8];
      end
      if (cfg_be[3]) begin
        next_wdata[15:8] = cfg_wdata[DATA_LSB + 8 +: 8];
      end
    end
    if (cfg_rd && cfg_hit(cfg_addr) && cfg_be[0]) begin
      next_al_ok = 1'b0;
    end
    if (ev_sw_done) begin
      next_start = 1'b0;
      next_err   = nacked;
      if (!job_wr && !nacked) begin
        next_wdata = rx_word;
      end
    end
    // hardware result beats a same-cycle read clear
    if (ev_al_end) begin
      next_al_ok    = ev_al_pass;
      next_al_first = 1'b0;
      if (al_first) begin
        next_al_fund = ev_al_pass;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      start        <= 1'b0;
      cmd          <= 1'b0;
      err          <= 1'b0;
      al_ok        <= 1'b0;
      al_fund      <= 1'b0;
      al_dis       <= RST_AL_DIS;
      al_first     <= 1'b1;
      rate         <= RST_RATE;
      waddr        <= 7'h00;
      wdata        <= 16'h0000;
      cfg_rdata    <= 32'h0000_0000;
      cfg_rd_valid <= 1'b0;
      pin_low      <= 1'b0;
    end else begin
      start        <= next_start;
      cmd          <= next_cmd;
      err          <= next_err;
      al_ok        <= next_al_ok;
      al_fund      <= next_al_fund;
      al_dis       <= next_al_dis;
      al_first     <= next_al_first;
      rate         <= next_rate;
      waddr        <= next_waddr;
      wdata        <= next_wdata;
      cfg_rdata    <= next_cfg_rdata;
      cfg_rd_valid <= cfg_rd;
      pin_low      <= 1'b0;
    end
  end

  // open drain: only ever pull low
  assign scl_o = pin_low;
  assign sda_o = pin_low;

  always_comb begin
    next_seq_st   = seq_st;
    next_job_al   = job_al;
    next_job_wr   = job_wr;
    next_step     = step;
    next_q        = q;
    next_bitn     = bitn;
    next_shreg    = shreg;
    next_rx_word  = rx_word;
    next_nacked   = nacked;
    next_scl_oe   = scl_oe;
    next_sda_oe   = sda_oe;
    next_al_req   = al_req || (hot_reset && !al_dis);
    next_al_idx   = al_idx;
    next_al_valid = 1'b0;
    next_al_addr  = al_addr;
    next_al_data  = al_data;
    next_al_busy  = al_busy;
    ev_sw_done    = 1'b0;
    ev_al_end     = 1'b0;
    ev_al_pass    = 1'b0;
    ok_word       = !nacked && (al_idx != 7'h00 || rx_word == AL_SIG);
    unique case (seq_st)
      S_IDLE: begin
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
        next_step   = 4'h0;
        next_q      = 2'h0;
        next_bitn   = 4'h0;
        next_nacked = 1'b0;
        // autoload goes first; a pending start waits for it
        if (al_req) begin
          next_seq_st  = S_RUN;
          next_job_al  = 1'b1;
          next_job_wr  = 1'b0;
          next_al_req  = 1'b0;
          next_al_idx  = 7'h00;
          next_al_busy = 1'b1;
        end else if (start) begin
          next_seq_st = S_RUN;
          next_job_al = 1'b0;
          next_job_wr = cmd;
        end
      end
      S_RUN: begin
        if (op == OP_END) begin
          if (!job_al) begin
            ev_sw_done  = 1'b1;
            next_seq_st = S_IDLE;
          end else begin
            if (ok_word && al_idx != 7'h00) begin
              next_al_valid = 1'b1;
              next_al_addr  = al_idx;
              next_al_data  = rx_word;
            end
            if (!ok_word || al_idx == AL_LAST_WORD) begin
              ev_al_end    = 1'b1;
              ev_al_pass   = ok_word;
              next_al_busy = 1'b0;
              next_seq_st  = S_IDLE;
            end else begin
              next_al_idx = al_idx + 7'h01;
              next_step   = 4'h0;
              next_q      = 2'h0;
              next_bitn   = 4'h0;
            end
          end
        end else if (ctl.tick) begin
          next_q = q + 2'h1;
          unique case (op)
            OP_START: begin
              next_sda_oe = (q >= 2'h2) ? 1'b1 : sda_oe;
              next_scl_oe = (q == 2'h1) ? 1'b0 : (q == 2'h3) ? 1'b1 : scl_oe;
            end
            OP_STOP: begin
              next_sda_oe = (q == 2'h0) ? 1'b1 : (q == 2'h2) ? 1'b0 : sda_oe;
              next_scl_oe = (q == 2'h1) ? 1'b0 : scl_oe;
            end
            OP_SEND, OP_RECV: begin
              if (q == 2'h0) begin
                if (bitn == 4'h8) begin
                  next_sda_oe = (op == OP_RECV) && (step == RD_HI_STEP);
                end else begin
                  next_sda_oe = (op == OP_SEND) && !shreg[7];
                end
              end else if (q == 2'h1) begin
                next_scl_oe = 1'b0;
              end else if (q == 2'h2) begin
                if (op == OP_SEND && bitn == 4'h8 && ctl.sda_seen) begin
                  next_nacked = 1'b1;
                end
                if (op == OP_RECV && bitn != 4'h8) begin
                  next_shreg = {shreg[6:0], ctl.sda_seen};
                end
              end else begin
                next_scl_oe = 1'b1;
                next_bitn   = bitn + 4'h1;
                if (op == OP_SEND) begin
                  next_shreg = {shreg[6:0], 1'b0};
                end
                if (op == OP_RECV && bitn == 4'h8) begin
                  next_rx_word = (step == RD_HI_STEP) ? {shreg, rx_word[7:0]}
                                                      : {rx_word[15:8], shreg};
                end
              end
            end
            OP_END: begin
              next_q = q;
            end
          endcase
          if (q == 2'h3 && (op == OP_START || op == OP_STOP || bitn == 4'h8)) begin
            // a nack skips straight to the stop condition
            next_step  = (next_nacked && op != OP_STOP) ? stop_step(job_wr)
                                                        : step + 4'h1;
            next_bitn  = 4'h0;
            next_shreg = byte_for(next_step, job_wr, job_al ? al_idx : waddr, wdata);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      seq_st   <= S_IDLE;
      job_al   <= 1'b0;
      job_wr   <= 1'b0;
      step     <= 4'h0;
      q        <= 2'h0;
      bitn     <= 4'h0;
      shreg    <= 8'h00;
      rx_word  <= 16'h0000;
      nacked   <= 1'b0;
      scl_oe   <= 1'b0;
      sda_oe   <= 1'b0;
      al_req   <= 1'b0;
      al_idx   <= 7'h00;
      al_valid <= 1'b0;
      al_addr  <= 7'h00;
      al_data  <= 16'h0000;
      al_busy  <= 1'b0;
    end else begin
      seq_st   <= next_seq_st;
      job_al   <= next_job_al;
      job_wr   <= next_job_wr;
      step     <= next_step;
      q        <= next_q;
      bitn     <= next_bitn;
      shreg    <= next_shreg;
      rx_word  <= next_rx_word;
      nacked   <= next_nacked;
      scl_oe   <= next_scl_oe;
      sda_oe   <= next_sda_oe;
      al_req   <= next_al_req;
      al_idx   <= next_al_idx;
      al_valid <= next_al_valid;
      al_addr  <= next_al_addr;
      al_data  <= next_al_data;
      al_busy  <= next_al_busy;
    end
  end

  sequence s_sw_launch;
    seq_st == S_IDLE && start && !al_req;
  endsequence
  sequence s_sw_finish;
    ev_sw_done;
  endsequence

  property p_launch;
    @(posedge clk) disable iff (!nrst) s_sw_launch |=> (seq_st == S_RUN && job_wr == cmd);
  endproperty
  a_launch: assert property (p_launch) else $error("start did not launch a cycle");

  property p_start_clear;
    @(posedge clk) disable iff (!nrst) s_sw_finish |=> (!start && seq_st == S_IDLE);
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start stayed set after cycle");

  property p_err_flag;
    @(posedge clk) disable iff (!nrst) s_sw_finish |=> (err == $past(nacked));
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag not tied to ack");

  property p_read_data;
    @(posedge clk) disable iff (!nrst)
      (s_sw_finish and (!job_wr && !nacked)) |=> (wdata == $past(rx_word));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read word not in data field");

  property p_reset_vals;
    @(posedge clk) !nrst |=> (rate == RST_RATE && al_dis && !start && !cmd && wdata == 16'h0000);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("wrong reset values");

  property p_rc_clear;
    @(posedge clk) disable iff (!nrst)
      (cfg_rd && cfg_hit(cfg_addr) && cfg_be[0] && !ev_al_end) |=> !al_ok;
  endproperty
  a_rc_clear: assert property (p_rc_clear) else $error("autoload bit not cleared by read");

  property p_fund_keep;
    @(posedge clk) disable iff (!nrst) (cfg_rd && !ev_al_end) |=> $stable(al_fund);
  endproperty
  a_fund_keep: assert property (p_fund_keep) else $error("fundamental autoload bit changed");

  property p_rdata;
    @(posedge clk) disable iff (!nrst)
      cfg_rd |=> (cfg_rd_valid && cfg_rdata[RSVD_BIT] == 1'b0 &&
                  (cfg_hit($past(cfg_addr)) || cfg_rdata == 32'h0000_0000));
  endproperty
  a_rdata: assert property (p_rdata) else $error("bad read answer");

  property p_wdata;
    @(posedge clk) disable iff (!nrst)
      (cfg_wr && cfg_hit(cfg_addr) && &cfg_be[3:2] && !start && !ev_sw_done)
        |=> (wdata == $past(cfg_wdata[31:16]));
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data not stored");

endmodule
`default_nettype wire

// ===== dv/sea_eeprom_model.sv
// behavioural two-wire eeprom on the access port's pins
// assumes both lines are resolved with pull-ups by the bench
`timescale 1ns/1ps
`default_nettype none
module sea_eeprom_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic nack,
  output var  logic pull
);
  logic [15:0] mem [128];
  logic [15:0] tx;
  logic [7:0]  sh;
  logic [6:0]  wa;
  logic        rd;
  logic        idle;
  int          bitn;
  int          byten;
  initial begin
    pull = 1'b0;
    idle = 1'b1;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // start or restart: data falls while clock is high
  always @(negedge sda) if (scl === 1'b1) begin
    idle = 1'b0;
    rd = 1'b0;
    bitn = 0;
    byten = 0;
    pull = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) idle = 1'b1;
  always @(posedge scl) if (!idle) begin
    if (bitn < 8 && !rd) sh = {sh[6:0], sda};
    // master nack on a read byte: stop driving until the next start
    if (bitn == 8 && rd && sda === 1'b1) idle = 1'b1;
    bitn = bitn + 1;
  end
  // drive only after the clock falls, never while it is high
  always @(negedge scl) if (!idle) begin
    if (bitn == 9) begin
      bitn = 0;
      byten = byten + 1;
    end
    pull = 1'b0;
    if (bitn == 8 && !rd) begin
      pull = !nack && (byten > 0 || sh[7:1] == 7'h50);
      if (byten == 0) rd = sh[0];
      if (byten == 0 && sh[0]) tx = mem[wa];
      if (byten == 1) wa = sh[7:1];
      if (byten == 2) tx[15:8] = sh;
      if (byten == 3) mem[wa] = {tx[15:8], sh};
    end else if (bitn < 8 && rd) begin
      pull = !tx[15];
      tx = tx << 1;
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the eeprom access port
// assumes the eeprom model and pull-up resolution below
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sea_pkg::*;
  logic        clk, nrst, hot_reset, cfg_wr, cfg_rd, nack, pull;
  logic        cfg_rd_valid, scl_oe, sda_oe, al_valid, al_busy;
  logic [11:0] cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, w;
  logic [6:0]  al_addr, a;
  logic [15:0] al_data, d;
  int          bad_count, check_count, cyc, al_cnt, busy_seen, c0;
  wire logic   scl = !scl_oe;
  wire logic   sda = !(sda_oe || pull);
  sea_access_port dut (.clk(clk), .nrst(nrst), .hot_reset(hot_reset), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .al_valid(al_valid), .al_addr(al_addr),
    .al_data(al_data), .al_busy(al_busy));
  sea_eeprom_model eep (.scl(scl), .sda(sda), .nack(nack), .pull(pull));
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  task automatic end_of_test;
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard: whole run needs well under this
  always @(posedge clk) begin
    cyc++;
    if (al_valid === 1'b1) al_cnt++;
    if (al_busy === 1'b1) busy_seen++;
    if (cyc == 60000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] word(input logic [6:0] wa, input logic [15:0] wd,
                                       input logic [7:0] ctl);
    return {wd, wa, 1'b0, ctl};
  endfunction
  task automatic wr(input logic [11:0] ad, input logic [31:0] v);
    @(posedge clk);
    #1 {cfg_wr, cfg_addr, cfg_wdata, cfg_be} = {1'b1, ad, v, 4'hF};
    @(posedge clk);
    #1 cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] ad, output logic [31:0] r);
    @(posedge clk);
    #1 {cfg_rd, cfg_addr, cfg_be} = {1'b1, ad, 4'hF};
    @(posedge clk);
    #1 cfg_rd = 1'b0;
    for (int i = 0; i < 3 && cfg_rd_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    r = cfg_rdata;
  endtask
  task automatic wait_done(output logic [31:0] r);
    rd(CFG_EEPROM_OFS, r);
    // the nacked cycle at the standard rate runs some eleven thousand clocks
    for (int i = 0; i < 8000 && r[START_BIT] !== 1'b0; i++) rd(CFG_EEPROM_OFS, r);
  endtask
  task automatic hot_pulse;
    @(posedge clk);
    #1 hot_reset = 1'b1;
    @(posedge clk);
    #1 hot_reset = 1'b0;
  endtask
  initial begin
    void'($urandom(32'h9ad1d45c));
    {nrst, hot_reset, cfg_wr, cfg_rd, nack, cfg_addr, cfg_be, cfg_wdata} = '0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    rd(CFG_EEPROM_OFS, w);
    chk(w, word(7'h00, 16'h0000, 8'h60));
    rd(12'h0C0, w);
    chk(w, 32'h0);
    wr(12'h0C0, 32'hFFFF_FFFF);
    rd(CFG_EEPROM_OFS, w);
    chk(w, word(7'h00, 16'h0000, 8'h60));
    nack = 1'b1;
    // standard rate: one serial clock period is the whole divide
    wr(CFG_EEPROM_OFS, word(7'h11, 16'hBEEF, 8'h63));
    @(posedge scl);
    c0 = cyc;
    @(posedge scl);
    chk(32'(cyc - c0), 32'(SCL_DIV_STD));
    wait_done(w);
    chk(w, word(7'h11, 16'hBEEF, 8'h66));
    nack = 1'b0;
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom);
      d = 16'($urandom);
      wr(CFG_EEPROM_OFS, word(a, d, 8'hE3) | 32'h100);
      // refused: a cycle is already running
      wr(CFG_EEPROM_OFS, ~word(a, d, 8'hFF));
      wait_done(w);
      chk(w, word(a, d, 8'hE2));
      chk(32'(eep.mem[a]), 32'(d));
      wr(CFG_EEPROM_OFS, word(a, ~d, 8'hE1));
      wait_done(w);
      chk(w, word(a, d, 8'hE0));
    end
    hot_pulse();
    repeat (20) @(posedge clk);
    chk(32'(busy_seen), 32'h0);
    eep.mem[0] = 16'h1234;
    wr(CFG_EEPROM_OFS, word(7'h00, 16'h0000, 8'hC0));
    hot_pulse();
    for (int i = 0; i < 4000 && (busy_seen == 0 || al_busy !== 1'b0); i++) begin
      @(posedge clk);
      #1;
    end
    rd(CFG_EEPROM_OFS, w);
    chk({24'h0, w[7:0]}, 32'hC0);
    chk(32'(al_cnt), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
